// File: rtl/ldo_enable_and_short_protect.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module ldo_enable_and_short_protect #(
   parameter int DEBOUNCE = ldo_ctrl_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        standby,
   input  wire logic [5:0]  short_detect,
   output logic [5:0]       ldo_on,
   output logic [5:0]       ldo_low_power,
   output logic [11:0]      pll_supply_mv,
   output logic [7:0]       pll_supply_max_ma,
   output logic             irq
);

   localparam int CW = $clog2(DEBOUNCE + 1);
   localparam logic [CW-1:0] DB_LAST = CW'(DEBOUNCE - 1);
   localparam logic [CW:0]   RUN_FULL = (CW + 1)'(DEBOUNCE + 1);

   ldo_ctrl_pkg::ldo_ctrl_t ctrl_r;
   logic                    scp_en_r;
   logic [1:0]              pll_sel_r;
   logic [5:0]              status_r;
   logic [5:0]              mask_r;
   logic [5:0]              confirmed;
   logic [5:0]              trip;
   logic [5:0]              clr_w1c;
   logic [2:0]              stby_s;
   logic                    stby_q;
   logic [5:0]              sd_s1;
   logic [5:0]              sd_s2;
   logic [5:0]              sd_s3;
   logic [5:0]              sd_lvl;
   logic                    wr;
   logic                    rd;
   logic                    addr_ok;

   assign wr     = psel && penable && pwrite;
   assign rd     = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr == ldo_ctrl_pkg::OFF_ENABLE) || (paddr == ldo_ctrl_pkg::OFF_STBY_SEL)
                 || (paddr == ldo_ctrl_pkg::OFF_LP_SEL) || (paddr == ldo_ctrl_pkg::OFF_CONFIG)
                 || (paddr == ldo_ctrl_pkg::OFF_IRQ_STATUS) || (paddr == ldo_ctrl_pkg::OFF_IRQ_MASK)
                 || (paddr == ldo_ctrl_pkg::OFF_STATE);
   assign pslverr = psel && penable && !addr_ok;

   // Standby input synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stby_s <= 3'h0;
         stby_q <= 1'b0;
      end else begin
         stby_s <= {stby_s[1:0], standby};
         if (stby_s[1] == stby_s[2]) begin
            stby_q <= stby_s[2];
         end
      end
   end

   // Short detect synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_s1  <= 6'h00;
         sd_s2  <= 6'h00;
         sd_s3  <= 6'h00;
         sd_lvl <= 6'h00;
      end else begin
         sd_s1 <= short_detect;
         sd_s2 <= sd_s1;
         sd_s3 <= sd_s2;
         for (int i = 0; i < 6; i++) begin
            if (sd_s2[i] == sd_s3[i]) begin
               sd_lvl[i] <= sd_s3[i];
            end
         end
      end
   end

   // Per-regulator debounce, short-protected regulators only
   generate
      for (genvar g = 0; g < 6; g++) begin : g_db
         if (ldo_ctrl_pkg::SCP_MASK_LDOS[g]) begin : g_scp
            ldo_ctrl_pkg::db_state_t st_r;
            logic [CW-1:0]           cnt_r;
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  st_r  <= ldo_ctrl_pkg::DB_IDLE;
                  cnt_r <= '0;
               end else begin
                  case (st_r)
                     ldo_ctrl_pkg::DB_IDLE: begin
                        cnt_r <= '0;
                        if (sd_lvl[g]) begin
                           st_r <= ldo_ctrl_pkg::DB_COUNT;
                        end
                     end
                     ldo_ctrl_pkg::DB_COUNT: begin
                        if (!sd_lvl[g]) begin
                           st_r <= ldo_ctrl_pkg::DB_IDLE;
                        end else if (cnt_r == DB_LAST) begin
                           st_r <= ldo_ctrl_pkg::DB_FAULT;
                        end else begin
                           cnt_r <= cnt_r + 1'b1;
                        end
                     end
                     ldo_ctrl_pkg::DB_FAULT: begin
                        if (!sd_lvl[g]) begin
                           st_r <= ldo_ctrl_pkg::DB_IDLE;
                        end
                     end
                     default: st_r <= ldo_ctrl_pkg::DB_IDLE;
                  endcase
               end
            end
            assign confirmed[g] = (st_r == ldo_ctrl_pkg::DB_FAULT);
         end else begin : g_none
            assign confirmed[g] = 1'b0;
         end
      end
   endgenerate

   // One trip per rising of a confirmed fault
   logic [5:0] confirmed_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         confirmed_q <= 6'h00;
      end else begin
         confirmed_q <= confirmed;
      end
   end
   assign trip = (confirmed & ~confirmed_q) & {6{scp_en_r}};

   assign clr_w1c = (wr && paddr == ldo_ctrl_pkg::OFF_IRQ_STATUS) ? pwdata[5:0] : 6'h00;

   // Enable bits; protection clear wins over a write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r.regulator_enable_bit <= ldo_ctrl_pkg::RST_ENABLE;
      end else begin
         if (wr && paddr == ldo_ctrl_pkg::OFF_ENABLE) begin
            ctrl_r.regulator_enable_bit <= pwdata[5:0] & ~trip;
         end else begin
            ctrl_r.regulator_enable_bit <= ctrl_r.regulator_enable_bit & ~trip;
         end
      end
   end

   // Standby and low-power select bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r.sleep_disable_select <= ldo_ctrl_pkg::RST_STBY_SEL;
         ctrl_r.low_power_select     <= ldo_ctrl_pkg::RST_LP_SEL;
      end else begin
         if (wr && paddr == ldo_ctrl_pkg::OFF_STBY_SEL) begin
            ctrl_r.sleep_disable_select <= pwdata[5:0];
         end
         if (wr && paddr == ldo_ctrl_pkg::OFF_LP_SEL) begin
            ctrl_r.low_power_select <= pwdata[5:0];
         end
      end
   end

   // Config register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scp_en_r  <= ldo_ctrl_pkg::RST_SCP_EN;
         pll_sel_r <= ldo_ctrl_pkg::RST_PLL_SEL;
      end else if (wr && paddr == ldo_ctrl_pkg::OFF_CONFIG) begin
         scp_en_r  <= pwdata[ldo_ctrl_pkg::CFG_SCP_EN_BIT];
         pll_sel_r <= pwdata[ldo_ctrl_pkg::CFG_PLL_SEL_LSB +: 2];
      end
   end

   // Sticky fault status, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= 6'h00;
         mask_r   <= ldo_ctrl_pkg::RST_MASK;
      end else begin
         status_r <= (status_r & ~clr_w1c) | trip;
         if (wr && paddr == ldo_ctrl_pkg::OFF_IRQ_MASK) begin
            mask_r <= pwdata[5:0];
         end
      end
   end

   assign irq = |(status_r & ~mask_r);

   // Regulator state resolution
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         ldo_on[i] = ctrl_r.regulator_enable_bit[i]
                   && !(ctrl_r.sleep_disable_select[i] && stby_q);
         if (ldo_ctrl_pkg::INTERNAL_PASS[i]) begin
            ldo_low_power[i] = 1'b0;
         end else begin
            ldo_low_power[i] = ctrl_r.regulator_enable_bit[i] && ctrl_r.low_power_select[i];
            if (ctrl_r.low_power_select[i]) begin
               ldo_on[i] = ctrl_r.regulator_enable_bit[i];
            end
         end
      end
   end

   // PLL supply decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_supply_mv     <= ldo_ctrl_pkg::PLL_MV_00;
         pll_supply_max_ma <= ldo_ctrl_pkg::PLL_MAX_MA;
      end else begin
         pll_supply_max_ma <= ldo_ctrl_pkg::PLL_MAX_MA;
         case (pll_sel_r)
            2'h0: pll_supply_mv <= ldo_ctrl_pkg::PLL_MV_00;
            2'h1: pll_supply_mv <= ldo_ctrl_pkg::PLL_MV_01;
            2'h2: pll_supply_mv <= ldo_ctrl_pkg::PLL_MV_10;
            2'h3: pll_supply_mv <= ldo_ctrl_pkg::PLL_MV_11;
            default: pll_supply_mv <= ldo_ctrl_pkg::PLL_MV_00;
         endcase
      end
   end

   // Read mux, programmed values plus fault status and synchronised short levels
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            ldo_ctrl_pkg::OFF_ENABLE:     prdata[5:0] = ctrl_r.regulator_enable_bit;
            ldo_ctrl_pkg::OFF_STBY_SEL:   prdata[5:0] = ctrl_r.sleep_disable_select;
            ldo_ctrl_pkg::OFF_LP_SEL:     prdata[5:0] = ctrl_r.low_power_select;
            ldo_ctrl_pkg::OFF_CONFIG: begin
               prdata[ldo_ctrl_pkg::CFG_SCP_EN_BIT]       = scp_en_r;
               prdata[ldo_ctrl_pkg::CFG_PLL_SEL_LSB +: 2] = pll_sel_r;
            end
            ldo_ctrl_pkg::OFF_IRQ_STATUS: prdata[5:0] = status_r;
            ldo_ctrl_pkg::OFF_IRQ_MASK:   prdata[5:0] = mask_r;
            ldo_ctrl_pkg::OFF_STATE:      prdata[5:0] = sd_lvl;
            default:                      prdata = 32'h0000_0000;
         endcase
      end
   end

   // Consecutive high samples on the dac fault input
   logic [CW:0] hi_run_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_run_r <= '0;
      end else if (!sd_lvl[1]) begin
         hi_run_r <= '0;
      end else if (hi_run_r != RUN_FULL) begin
         hi_run_r <= hi_run_r + 1'b1;
      end
   end

   // Checks
   chk_trip_clears_en: assert property (@(posedge pclk) disable iff (!presetn)
      trip[1] |=> !ctrl_r.regulator_enable_bit[1] && status_r[1])
      else $error("fault did not clear enable or set flag");
   chk_no_protect_off: assert property (@(posedge pclk) disable iff (!presetn)
      !scp_en_r |=> (status_r & ~$past(status_r)) == 6'h00)
      else $error("fault flag set while protection disabled");
   chk_en_kept_off: assert property (@(posedge pclk) disable iff (!presetn)
      !scp_en_r && !(wr && paddr == ldo_ctrl_pkg::OFF_ENABLE)
      |=> ctrl_r.regulator_enable_bit == $past(ctrl_r.regulator_enable_bit))
      else $error("enable cleared while protection disabled");
   chk_mask_gates_irq: assert property (@(posedge pclk) disable iff (!presetn)
      ((status_r & ~mask_r) == 6'h00) |-> !irq)
      else $error("irq raised while masked");
   chk_irq_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
      (status_r & ~mask_r) != 6'h00 |-> irq)
      else $error("unmasked fault did not raise irq");
   chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      status_r[2] && clr_w1c[2] == 1'b0 |=> status_r[2])
      else $error("fault flag dropped without clear");
   chk_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
      clr_w1c[2] && !trip[2] |=> !status_r[2])
      else $error("fault flag not cleared by write");
   chk_standby_off: assert property (@(posedge pclk) disable iff (!presetn)
      stby_q && ctrl_r.sleep_disable_select[0] |-> !ldo_on[0])
      else $error("pll supply on during standby");
   chk_stby_on: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r.regulator_enable_bit[2] && !stby_q |-> ldo_on[2])
      else $error("enabled regulator off without standby");
   chk_en_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.regulator_enable_bit[4] |-> !ldo_on[4])
      else $error("disabled regulator on");
   chk_no_stby_eff: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r.sleep_disable_select[4] |-> ldo_on[4] == ctrl_r.regulator_enable_bit[4])
      else $error("standby affected unselected regulator");
   chk_int_no_lp: assert property (@(posedge pclk) disable iff (!presetn)
      ldo_low_power[0] == 1'b0 && ldo_low_power[2] == 1'b0 && ldo_low_power[4] == 1'b0)
      else $error("low power on internal pass regulator");
   chk_rd_enable: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == ldo_ctrl_pkg::OFF_ENABLE |-> prdata[5:0] == ctrl_r.regulator_enable_bit)
      else $error("enable readback differs from programmed value");
   chk_pll_decode: assert property (@(posedge pclk) disable iff (!presetn)
      pll_sel_r == 2'h3 && $stable(pll_sel_r) |=> pll_supply_mv == ldo_ctrl_pkg::PLL_MV_11)
      else $error("pll decode wrong");
   chk_pll_mid: assert property (@(posedge pclk) disable iff (!presetn)
      pll_sel_r == 2'h2 |=> pll_supply_mv == ldo_ctrl_pkg::PLL_MV_10)
      else $error("pll decode wrong for middle code");
   chk_pll_low: assert property (@(posedge pclk) disable iff (!presetn)
      pll_sel_r == 2'h1 |=> pll_supply_mv == ldo_ctrl_pkg::PLL_MV_01)
      else $error("pll decode wrong for low code");
   chk_debounce_len: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(confirmed[1]) |-> $past(sd_lvl[1], 2))
      else $error("fault confirmed without stable input");
   chk_debounce_run: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(confirmed[1]) |-> hi_run_r == RUN_FULL)
      else $error("fault confirmed before debounce ran out");
   chk_fault_confirm: assert property (@(posedge pclk) disable iff (!presetn)
      hi_run_r == RUN_FULL |-> confirmed[1])
      else $error("fault not confirmed after debounce ran out");
   chk_reset_scp: assert property (@(posedge pclk)
      $rose(presetn) |-> !scp_en_r)
      else $error("protect enable not clear after reset");

   cov_trip: cover property (@(posedge pclk) disable iff (!presetn) trip != 6'h00);
   cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   cov_standby: cover property (@(posedge pclk) disable iff (!presetn) stby_q && ldo_on[0] == 1'b0
      && ctrl_r.regulator_enable_bit[0]);
   cov_masked_fault: cover property (@(posedge pclk) disable iff (!presetn) status_r != 6'h00 && !irq);
   cov_pll_top: cover property (@(posedge pclk) disable iff (!presetn) pll_sel_r == 2'h3);

endmodule : ldo_enable_and_short_protect

// File: shared/ldo_ctrl_pkg.sv
package ldo_ctrl_pkg;

   // Regulator indices
   localparam int NUM_LDO   = 6;
   localparam int LDO_PLL   = 0;
   localparam int LDO_DAC   = 1;
   localparam int LDO_USB   = 2;
   localparam int LDO_USB2  = 3;
   localparam int LDO_GEN1  = 4;
   localparam int LDO_GEN2  = 5;

   // Regulators with short protection
   localparam logic [5:0] SCP_MASK_LDOS   = 6'h3E;
   // Regulators with internal pass device
   localparam logic [5:0] INTERNAL_PASS   = 6'h15;

   // Register byte offsets
   localparam logic [7:0] OFF_ENABLE      = 8'h00;
   localparam logic [7:0] OFF_STBY_SEL    = 8'h04;
   localparam logic [7:0] OFF_LP_SEL      = 8'h08;
   localparam logic [7:0] OFF_CONFIG      = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STATUS  = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK    = 8'h14;
   localparam logic [7:0] OFF_STATE       = 8'h18;

   // Config fields
   localparam int CFG_SCP_EN_BIT   = 0;
   localparam int CFG_PLL_SEL_LSB  = 4;

   // Reset values
   localparam logic [5:0] RST_ENABLE      = 6'h00;
   localparam logic [5:0] RST_STBY_SEL    = 6'h00;
   localparam logic [5:0] RST_LP_SEL      = 6'h00;
   localparam logic       RST_SCP_EN      = 1'b0;
   localparam logic [1:0] RST_PLL_SEL     = 2'h0;
   localparam logic [5:0] RST_MASK        = 6'h3F;

   // Debounce default in cycles
   localparam int DEBOUNCE_CYCLES = 100;

   // PLL supply output in millivolts, current limit in milliamps
   localparam logic [11:0] PLL_MV_00 = 12'h4B0;
   localparam logic [11:0] PLL_MV_01 = 12'h4E2;
   localparam logic [11:0] PLL_MV_10 = 12'h5DC;
   localparam logic [11:0] PLL_MV_11 = 12'h708;
   localparam logic [7:0]  PLL_MAX_MA = 8'h32;

   typedef struct packed {
      logic [5:0] regulator_enable_bit;
      logic [5:0] sleep_disable_select;
      logic [5:0] low_power_select;
   } ldo_ctrl_t;

   typedef enum logic [2:0] {
      DB_IDLE  = 3'b001,
      DB_COUNT = 3'b010,
      DB_FAULT = 3'b100
   } db_state_t;

endpackage : ldo_ctrl_pkg

// File: sim/ldo_host_model.sv
`timescale 1ns/1ps
module ldo_host_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       irq,
   input  wire logic       standby_req,
   output logic            standby,
   output logic [7:0]      irq_count
);
   logic irq_r;
   // Standby event level, changed only after an edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby <= 1'b0;
      end else begin
         standby <= standby_req;
      end
   end
   // Counts interrupt requests seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r     <= 1'b0;
         irq_count <= 8'h00;
      end else begin
         irq_r <= irq;
         if (irq && !irq_r) begin
            irq_count <= irq_count + 8'h01;
         end
      end
   end
endmodule : ldo_host_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int DB = 2;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        standby;
   logic        sb_req;
   logic [5:0]  short_detect;
   logic [5:0]  ldo_on;
   logic [5:0]  ldo_lp;
   logic [11:0] pll_mv;
   logic [7:0]  pll_ma;
   logic        irq;
   logic [7:0]  irq_count;
   int          mismatches;
   int          cmp_count;

   ldo_enable_and_short_protect #(.DEBOUNCE(DB)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .standby(standby), .short_detect(short_detect),
      .ldo_on(ldo_on), .ldo_low_power(ldo_lp), .pll_supply_mv(pll_mv), .pll_supply_max_ma(pll_ma), .irq(irq));
   ldo_host_model host (.pclk(pclk), .presetn(presetn), .irq(irq), .standby_req(sb_req),
      .standby(standby), .irq_count(irq_count));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int   n;
      logic rdy;
      n = 0;
      rdy = 1'b0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(negedge pclk);
         rdy = pready;
         rd  = prdata;
         err = pslverr;
         n++;
         @(posedge pclk);
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         mismatches++;
         $display("[FAIL] pready expected 1 seen %b", rdy);
         finish_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, wd, rd, err);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(what, exp, rd);
   endtask : rd_chk

   task automatic test_reset();
      logic [31:0] rd;
      logic        err;
      rd_chk("config", ldo_ctrl_pkg::OFF_CONFIG, 32'h0);
      rd_chk("mask", ldo_ctrl_pkg::OFF_IRQ_MASK, 32'h3F);
      rd_chk("enable", ldo_ctrl_pkg::OFF_ENABLE, 32'h0);
      apb(1'b0, 8'h1C, 32'h0, rd, err);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_pll();
      for (int c = 0; c < 4; c++) begin
         wr(ldo_ctrl_pkg::OFF_CONFIG, 32'(c) << ldo_ctrl_pkg::CFG_PLL_SEL_LSB);
         repeat (2) @(posedge pclk);
         chk("pll mv", (c == 0) ? 32'h4B0 : (c == 1) ? 32'h4E2 : (c == 2) ? 32'h5DC : 32'h708, 32'(pll_mv));
         chk("pll ma", 32'h32, 32'(pll_ma));
      end
      $display("test_pll done");
   endtask : test_pll

   task automatic test_standby();
      logic [5:0] en;
      logic [5:0] exp;
      logic [5:0] ext;
      ext = ~ldo_ctrl_pkg::INTERNAL_PASS;
      for (int i = 0; i < 16; i++) begin
         en = i[0] ? 6'h3F : 6'h00;
         wr(ldo_ctrl_pkg::OFF_ENABLE, 32'(en));
         wr(ldo_ctrl_pkg::OFF_STBY_SEL, i[1] ? 32'h3F : 32'h0);
         wr(ldo_ctrl_pkg::OFF_LP_SEL, i[2] ? 32'h3F : 32'h0);
         sb_req <= i[3];
         repeat (10) @(posedge pclk);
         exp = (i[0] && !(i[1] && i[3])) ? ldo_ctrl_pkg::INTERNAL_PASS : 6'h00;
         chk("internal on", 32'(exp), 32'(ldo_on & ldo_ctrl_pkg::INTERNAL_PASS));
         chk("low power", (i[0] && i[2]) ? 32'(ext) : 32'h0, 32'(ldo_lp));
         chk("external on", (i[0] && (i[2] || !(i[1] && i[3]))) ? 32'(ext) : 32'h0, 32'(ldo_on & ext));
         rd_chk("enable readback", ldo_ctrl_pkg::OFF_ENABLE, 32'(en));
      end
      sb_req <= 1'b0;
      wr(ldo_ctrl_pkg::OFF_STBY_SEL, 32'h0);
      wr(ldo_ctrl_pkg::OFF_LP_SEL, 32'h0);
      $display("test_standby done");
   endtask : test_standby

   task automatic test_protect_off();
      wr(ldo_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
      wr(ldo_ctrl_pkg::OFF_ENABLE, 32'h3F);
      short_detect <= 6'h3F;
      repeat (20) @(posedge pclk);
      chk("irq off", 32'h0, 32'(irq));
      rd_chk("enable kept", ldo_ctrl_pkg::OFF_ENABLE, 32'h3F);
      rd_chk("status idle", ldo_ctrl_pkg::OFF_IRQ_STATUS, 32'h0);
      rd_chk("short levels", ldo_ctrl_pkg::OFF_STATE, 32'h3F);
      short_detect <= 6'h00;
      repeat (10) @(posedge pclk);
      $display("test_protect_off done");
   endtask : test_protect_off

   task automatic test_protect_on();
      int n;
      wr(ldo_ctrl_pkg::OFF_CONFIG, 32'h1);
      @(posedge pclk);
      short_detect <= 6'h3F;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (ldo_on[5:1] !== 5'h00 && n < 40);
      if (ldo_on[5:1] !== 5'h00) begin
         mismatches++;
         $display("[FAIL] fault trip expected within 40 cycles seen none");
         finish_test();
      end
      chk("debounced", 32'h1, 32'(n >= DB + 6 && n <= DB + 8));
      chk("trip off", 32'h01, 32'(ldo_on));
      chk("irq set", 32'h1, 32'(irq));
      rd_chk("enable cleared", ldo_ctrl_pkg::OFF_ENABLE, 32'h01);
      wr(ldo_ctrl_pkg::OFF_IRQ_MASK, 32'h3F);
      @(posedge pclk);
      chk("irq masked", 32'h0, 32'(irq));
      short_detect <= 6'h00;
      repeat (10) @(posedge pclk);
      rd_chk("status sticky", ldo_ctrl_pkg::OFF_IRQ_STATUS, 32'h3E);
      wr(ldo_ctrl_pkg::OFF_IRQ_STATUS, 32'h3E);
      rd_chk("status clear", ldo_ctrl_pkg::OFF_IRQ_STATUS, 32'h0);
      wr(ldo_ctrl_pkg::OFF_ENABLE, 32'h3F);
      rd_chk("re-enable", ldo_ctrl_pkg::OFF_ENABLE, 32'h3F);
      chk("re-enabled on", 32'h3F, 32'(ldo_on));
      chk("irq rises", 32'h1, 32'(irq_count));
      $display("test_protect_on done");
   endtask : test_protect_on

   initial begin
      mismatches = 0;
      cmp_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sb_req = 1'b0;
      short_detect = 6'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_pll();
      test_standby();
      test_protect_off();
      test_protect_on();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      $display("[FAIL] run length expected below 20000 cycles seen 20000");
      finish_test();
   end
endmodule : tb
